// ---- hdl/cgr_clock_gating_reset.sv ----
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "cgr_defines.svh"
// Notes on behaviour
// - Timer A enable drops while gate bit 5 of gate A is set; state kept.
// - Timer B enable drops while gate bit 3 of gate A is set; state kept.
// - Sync serial clock stops while gate bit 2 of gate A is set.
// - Gate A bits 4, 1 and 0 read zero always.
// - USB function clock stops while gate bit 7 of gate B is set.
// - Serial port clock stops while gate bit 0 of gate B is set.
// - Gate B bits 6..1 read zero; whole register resets to zero.
// - Comparator disabled in non-idle sleep unless it uses internal reference.
// - Internal reference on only when brown-out or comparator asks for it.
// - Fuse-enabled brown-out detector stays on in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - Digital inputs disabled in sleeps stopping I/O clock, except wake inputs.
// - Debug fuse keeps main clock source enabled during sleep.
// - Reset loads registers with initial values; core starts at reset vector.
// - Port reset output follows power-on, pin and brown-out without a clock; watchdog and USB pass synchronisers.
// - Internal reset stretched by fuse-selected time-out after sources release; here the TOUT_CYC parameter sets it.
// - Power-on detector low holds the core in reset.
// - External reset low beyond minimum width resets; driver holds it long enough.
// - Watchdog expiry resets only while watchdog is enabled.
// - Enabled brown-out detector below trigger level resets.
// - USB bus reset resets core while USB function remains enabled.
// - Gated peripheral is frozen and its register access blocked.
// - Watchdog reset is a one-cycle pulse; time-out starts at its fall.
// - Each source sets its flag; write zero clears; power-on clears others.
// - Power-on flag set by power-on reset, cleared only by writing zero.
module cgr_clock_gating_reset #(
  parameter int unsigned TOUT_CYC = `CGR_TOUT_DEFAULT
) (
  // Clock and reset.
  input  wire logic                    sys_clk_in,
  input  wire logic                    sys_rst_in,
  // Wishbone slave.
  input  wire logic                    wb_cyc_in,
  input  wire logic                    wb_stb_in,
  input  wire logic                    wb_we_in,
  input  wire logic [3:0]              wb_adr_in,
  input  wire logic [3:0]              wb_sel_in,
  input  wire logic [31:0]             wb_dat_in,
  output logic      [31:0]             wb_dat_out,
  output logic                         wb_ack_out,
  // Reset sources.
  input  wire logic                    poweron_low_in,
  input  wire logic                    ext_reset_n_in,
  input  wire logic                    wdt_expire_in,
  input  wire logic                    wdt_enable_in,
  input  wire logic                    brownout_low_in,
  input  wire logic                    usb_bus_reset_in,
  input  wire logic                    usb_reset_mcu_en_in,
  // Fuses and sleep state.
  input  wire logic [2:0]              brownout_level_fuses_in,
  input  wire logic                    debug_enable_fuse_in,
  input  wire logic                    sleep_active_in,
  input  wire logic                    comparator_enable_in,
  input  wire logic                    comparator_uses_ref_in,
  input  wire logic [7:0]              wake_input_mask_in,
  input  wire logic                    periph_sel_timer_a_in,
  input  wire logic                    periph_sel_timer_b_in,
  input  wire logic                    periph_sel_sync_serial_in,
  input  wire logic                    periph_sel_usb_in,
  input  wire logic                    periph_sel_serial_in,
  // Gating and power outputs.
  output cgr_pkg::cgr_clk_en_type      clk_en_out,
  output logic                         periph_access_ok_out,
  output logic                         comparator_power_out,
  output logic                         vref_enable_out,
  output logic                         brownout_enable_out,
  output logic                         wdt_run_out,
  output logic [7:0]                   input_buffer_en_out,
  output logic                         main_clock_en_out,
  output logic                         usb_keep_enabled_out,
  // Reset outputs.
  output logic                         port_reset_out,
  output logic                         core_reset_out
);
  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [7:0]             gate_a;
  logic [7:0]             gate_b;
  logic [7:0]             cause;
  logic [3:0]             sleep_reg;
  cgr_pkg::cgr_sleep_type sleep_mode;
  logic                   wb_hit;
  logic                   wb_wr;
  logic                   brownout_on;
  logic [2:0]             ext_sync;
  logic                   ext_low;
  logic [7:0]             ext_cnt;
  logic                   ext_reset;
  logic                   wdt_pulse;
  logic [2:0]             wdt_sync;
  logic                   wdt_seen;
  logic [2:0]             usb_sync;
  logic                   usb_reset;
  logic                   any_source;
  logic [16:0]            tout_cnt;
  cgr_pkg::cgr_state_type state;
  cgr_pkg::cgr_state_type next_state;

  assign sleep_mode = cgr_pkg::cgr_sleep_type'(sleep_reg[3:1]);
  assign wb_hit     = wb_cyc_in && wb_stb_in && !wb_ack_out;
  // Writes land on the edge at which the master samples the acknowledge.
  assign wb_wr      = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0];

  // ----------------------------------------------------------------
  // Bus slave: one registered ack per request, zero on unmapped reads.
  // ----------------------------------------------------------------
  // Acknowledge one cycle after the request appears, then drop.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_hit;
    end
  end

  // Read data mux; reserved bits come back zero through the masks.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_hit) begin
      unique case (wb_adr_in)
        `CGR_OFS_GATE_A: wb_dat_out <= {24'h00_0000, gate_a & `CGR_MASK_GATE_A};
        `CGR_OFS_GATE_B: wb_dat_out <= {24'h00_0000, gate_b & `CGR_MASK_GATE_B};
        `CGR_OFS_CAUSE:  wb_dat_out <= {24'h00_0000, cause};
        `CGR_OFS_SLEEP:  wb_dat_out <= {28'h000_0000, sleep_reg};
        default:         wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // Gate registers; only documented bits store, so reserved bits stay zero.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || core_reset_out) begin
      gate_a <= `CGR_RST_GATE_A;
      gate_b <= `CGR_RST_GATE_B;
    end else if (wb_wr && wb_adr_in == `CGR_OFS_GATE_A) begin
      gate_a <= wb_dat_in[7:0] & `CGR_MASK_GATE_A;
    end else if (wb_wr && wb_adr_in == `CGR_OFS_GATE_B) begin
      gate_b <= wb_dat_in[7:0] & `CGR_MASK_GATE_B;
    end
  end

  // Sleep mode register: mode in bits 3..1, sleep enable in bit 0.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || core_reset_out) begin
      sleep_reg <= 4'h0;
    end else if (wb_wr && wb_adr_in == `CGR_OFS_SLEEP) begin
      sleep_reg <= wb_dat_in[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Clock gating.
  // ----------------------------------------------------------------
  // Enables drop while gated; peripherals hold their state when disabled.
  always_comb begin
    clk_en_out.timer_a      = !gate_a[`CGR_BIT_TIMER_A];
    clk_en_out.timer_b      = !gate_a[`CGR_BIT_TIMER_B];
    clk_en_out.sync_serial  = !gate_a[`CGR_BIT_SYNC_SER];
    clk_en_out.usb_function = !gate_b[`CGR_BIT_USB];
    clk_en_out.serial_port  = !gate_b[`CGR_BIT_SER_PORT];
  end

  // Register access to a gated peripheral is blocked.
  assign periph_access_ok_out = !((periph_sel_timer_a_in && gate_a[`CGR_BIT_TIMER_A]) ||
                                  (periph_sel_timer_b_in && gate_a[`CGR_BIT_TIMER_B]) ||
                                  (periph_sel_sync_serial_in && gate_a[`CGR_BIT_SYNC_SER]) ||
                                  (periph_sel_usb_in && gate_b[`CGR_BIT_USB]) ||
                                  (periph_sel_serial_in && gate_b[`CGR_BIT_SER_PORT]));

  // ----------------------------------------------------------------
  // Sleep power control.
  // ----------------------------------------------------------------
  // Level fuses all ones mean the detector is off.
  assign brownout_on = (brownout_level_fuses_in != 3'h7);
  // Brown-out follows only its fuses, never the sleep state.
  assign brownout_enable_out = brownout_on;
  // Comparator powers down in deeper sleep unless it feeds off the reference.
  assign comparator_power_out = comparator_enable_in &&
                                (!sleep_active_in || sleep_mode == cgr_pkg::CGR_SLP_IDLE ||
                                 comparator_uses_ref_in);
  // Reference is on only for its two consumers.
  assign vref_enable_out = brownout_on || (comparator_power_out && comparator_uses_ref_in);
  // Watchdog is never stopped by sleep.
  assign wdt_run_out = wdt_enable_in;
  // Only idle keeps the I/O clock; other sleeps keep wake inputs only.
  assign input_buffer_en_out = (sleep_active_in && sleep_mode != cgr_pkg::CGR_SLP_IDLE) ?
                               wake_input_mask_in : 8'hFF;
  // Main clock runs when awake, in idle, standby and extended standby, or under debug.
  assign main_clock_en_out = !sleep_active_in || debug_enable_fuse_in ||
                             sleep_mode == cgr_pkg::CGR_SLP_IDLE ||
                             sleep_mode == cgr_pkg::CGR_SLP_STANDBY ||
                             sleep_mode == cgr_pkg::CGR_SLP_EXTSTBY;
  // USB reset of the core leaves the function powered.
  assign usb_keep_enabled_out = 1'b1;

  // ----------------------------------------------------------------
  // Reset sources.
  // ----------------------------------------------------------------
  // External pin synchroniser, three stages; stages two and three must agree.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ext_sync <= 3'b111;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_reset_n_in};
    end
  end
  assign ext_low = !ext_sync[1] && !ext_sync[2];

  // Low must persist the minimum width before it counts as a reset.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !ext_low) begin
      ext_cnt <= 8'h00;
    end else if (ext_cnt < 8'(`CGR_EXT_MIN_CYC)) begin
      ext_cnt <= ext_cnt + 8'h01;
    end
  end
  assign ext_reset = ext_low && (ext_cnt >= 8'(`CGR_EXT_MIN_CYC));

  // Watchdog expiry comes from the watchdog's own oscillator: three stages, and the
  // accepted level moves only once stages two and three agree.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wdt_sync <= 3'h0;
      wdt_seen <= 1'b0;
    end else begin
      wdt_sync <= {wdt_sync[1:0], wdt_expire_in};
      if (wdt_sync[1] == wdt_sync[2]) begin
        wdt_seen <= wdt_sync[2];
      end
    end
  end
  // A newly accepted expiry becomes a single-cycle pulse when enabled.
  assign wdt_pulse = wdt_enable_in && wdt_sync[1] && wdt_sync[2] && !wdt_seen;

  // USB bus reset comes from the USB clock domain and passes the same three stages.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      usb_sync <= 3'h0;
    end else begin
      usb_sync <= {usb_sync[1:0], usb_bus_reset_in};
    end
  end
  assign usb_reset = usb_reset_mcu_en_in && usb_sync[1] && usb_sync[2];

  // Any active source; power-on and pin act also without a clock.
  assign any_source = poweron_low_in || ext_reset || wdt_pulse ||
                      (brownout_on && brownout_low_in) ||
                      usb_reset;
  assign port_reset_out = poweron_low_in || !ext_reset_n_in || core_reset_out;

  // ----------------------------------------------------------------
  // Delay counter stretching the internal reset.
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      cgr_pkg::CGR_ST_HOLD:  if (!any_source) next_state = cgr_pkg::CGR_ST_DELAY;
      cgr_pkg::CGR_ST_DELAY: if (any_source) next_state = cgr_pkg::CGR_ST_HOLD;
                             else if (tout_cnt >= 17'(TOUT_CYC - 1)) next_state = cgr_pkg::CGR_ST_RUN;
      cgr_pkg::CGR_ST_RUN:   if (any_source) next_state = cgr_pkg::CGR_ST_HOLD;
      default:               next_state = cgr_pkg::CGR_ST_HOLD;
    endcase
  end

  // State and time-out count advance together.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state    <= cgr_pkg::CGR_ST_HOLD;
      tout_cnt <= 17'h0_0000;
    end else begin
      state    <= next_state;
      tout_cnt <= (state == cgr_pkg::CGR_ST_DELAY) ? tout_cnt + 17'h0_0001 : 17'h0_0000;
    end
  end
  assign core_reset_out = (state != cgr_pkg::CGR_ST_RUN) || any_source;

  // ----------------------------------------------------------------
  // Reset cause flags.
  // ----------------------------------------------------------------
  // Sources set their flag; a written zero clears; sets win over clears.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cause    <= `CGR_RST_CAUSE;
    end else begin
      if (wb_wr && wb_adr_in == `CGR_OFS_CAUSE) begin
        cause <= cause & wb_dat_in[7:0] & `CGR_MASK_CAUSE;
      end
      if (poweron_low_in) begin
        cause <= 8'h01;
      end else begin
        if (usb_reset) cause[`CGR_BIT_USB_FLAG] <= 1'b1;
        if (wdt_pulse) cause[`CGR_BIT_WDT_FLAG] <= 1'b1;
        if (brownout_on && brownout_low_in) cause[`CGR_BIT_BOD_FLAG] <= 1'b1;
        if (ext_reset) cause[`CGR_BIT_EXT_FLAG] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  AST_TIMER_A_GATE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wb_wr && wb_adr_in == `CGR_OFS_GATE_A && wb_dat_in[5] && !core_reset_out) |=> !clk_en_out.timer_a)
    else $error("timer A not gated");
  AST_TIMER_B_GATE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wb_wr && wb_adr_in == `CGR_OFS_GATE_A && !core_reset_out) |=> clk_en_out.timer_b == !$past(wb_dat_in[3]))
    else $error("timer B enable wrong");
  AST_GATE_A_RSV: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wb_hit && !wb_we_in && wb_adr_in == `CGR_OFS_GATE_A) |=> wb_dat_out[4] == 1'b0 && wb_dat_out[1:0] == 2'b00)
    else $error("gate A reserved bits nonzero");
  AST_GATE_B_RSV: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wb_hit && wb_adr_in == `CGR_OFS_GATE_B) |=> wb_dat_out[6:1] == 6'h00)
    else $error("gate B reserved bits nonzero");
  AST_COMP_SLEEP: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (sleep_active_in && sleep_mode == cgr_pkg::CGR_SLP_PDOWN && !comparator_uses_ref_in) |-> !comparator_power_out)
    else $error("comparator on in deep sleep");
  AST_WDT_PULSE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wdt_pulse |=> !wdt_pulse) else $error("watchdog pulse longer than one cycle");
  AST_STRETCH: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($fell(any_source) && state == cgr_pkg::CGR_ST_HOLD) |-> core_reset_out [*2])
    else $error("internal reset not stretched");
  AST_POR_HOLD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    poweron_low_in |-> core_reset_out ##1 cause == 8'h01) else $error("power-on not holding reset");
  AST_EXT_FLAG: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (ext_reset && !poweron_low_in) |=> cause[1]) else $error("external flag not set");
  AST_DEBUG_CLK: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    debug_enable_fuse_in |-> main_clock_en_out) else $error("main clock off under debug");
  AST_PORT_RESET: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (poweron_low_in || !ext_reset_n_in) |-> port_reset_out)
    else $error("port reset not following its source");
  AST_WDT_OFF: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !wdt_enable_in |-> !wdt_pulse)
    else $error("watchdog reset while disabled");
  AST_GATED_ACCESS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (periph_sel_timer_a_in && !clk_en_out.timer_a) |-> !periph_access_ok_out)
    else $error("access to gated peripheral allowed");
  COV_WDT: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) wdt_pulse ##[1:20] !core_reset_out);
  COV_EXT: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) ext_reset);
  COV_RUN: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $rose(state == cgr_pkg::CGR_ST_RUN));
  COV_GATE: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) !clk_en_out.usb_function);
  COV_USB: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) usb_reset);
endmodule : cgr_clock_gating_reset

// ---- hdl/cgr_defines.svh ----
`ifndef CGR_DEFINES_SVH
`define CGR_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the bus).
// ----------------------------------------------------------------
`define CGR_OFS_GATE_A     4'h0
`define CGR_OFS_GATE_B     4'h4
`define CGR_OFS_CAUSE      4'h8
`define CGR_OFS_SLEEP      4'hC
// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define CGR_BIT_TIMER_A    5
`define CGR_BIT_TIMER_B    3
`define CGR_BIT_SYNC_SER   2
`define CGR_BIT_USB        7
`define CGR_BIT_SER_PORT   0
`define CGR_BIT_USB_FLAG   5
`define CGR_BIT_WDT_FLAG   3
`define CGR_BIT_BOD_FLAG   2
`define CGR_BIT_EXT_FLAG   1
`define CGR_BIT_POR_FLAG   0
// ----------------------------------------------------------------
// Writable masks and reset values.
// ----------------------------------------------------------------
`define CGR_MASK_GATE_A    8'h2C
`define CGR_MASK_GATE_B    8'h81
`define CGR_MASK_CAUSE     8'h2F
`define CGR_RST_GATE_A     8'h00
`define CGR_RST_GATE_B     8'h00
`define CGR_RST_CAUSE      8'h01
// ----------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------
`define CGR_CLK_MHZ        40
`define CGR_EXT_MIN_NS     400
`define CGR_EXT_MIN_CYC    ((`CGR_EXT_MIN_NS * `CGR_CLK_MHZ + 999) / 1000)
`define CGR_TOUT_DEFAULT   65536
`endif

// ---- hdl/cgr_pkg.sv ----
package cgr_pkg;
  // Gated-peripheral enable set.
  typedef struct packed {
    logic timer_a;
    logic timer_b;
    logic sync_serial;
    logic usb_function;
    logic serial_port;
  } cgr_clk_en_type;
  // Sleep mode codes.
  typedef enum logic [2:0] {
    CGR_SLP_IDLE    = 3'h0,
    CGR_SLP_RSV1    = 3'h1,
    CGR_SLP_PDOWN   = 3'h2,
    CGR_SLP_PSAVE   = 3'h3,
    CGR_SLP_RSV4    = 3'h4,
    CGR_SLP_RSV5    = 3'h5,
    CGR_SLP_STANDBY = 3'h6,
    CGR_SLP_EXTSTBY = 3'h7
  } cgr_sleep_type;
  // Reset sequencer states.
  typedef enum logic [1:0] {
    CGR_ST_HOLD  = 2'b00,
    CGR_ST_DELAY = 2'b01,
    CGR_ST_RUN   = 2'b10
  } cgr_state_type;
endpackage : cgr_pkg

// ---- tb/cgr_testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic                    sys_clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [3:0]              wb_adr_in, wb_sel_in;
  logic [31:0]             wb_dat_in, wb_dat_out, rd;
  logic                    poweron_low_in, ext_reset_n_in, wdt_expire_in, wdt_enable_in, brownout_low_in;
  logic                    usb_bus_reset_in, usb_reset_mcu_en_in, debug_enable_fuse_in, sleep_active_in;
  logic                    comparator_enable_in, comparator_uses_ref_in, sel_a, sel_b, sel_s, sel_u, sel_p;
  logic [2:0]              brownout_level_fuses_in;
  logic [7:0]              wake_input_mask_in, input_buffer_en_out;
  logic                    periph_access_ok_out, comparator_power_out, vref_enable_out, brownout_enable_out;
  logic                    wdt_run_out, main_clock_en_out, usb_keep_enabled_out, port_reset_out, core_reset_out;
  cgr_pkg::cgr_clk_en_type clk_en_out;
  int                      n_fail, samples_checked, n;
  localparam int TOUT = 16;
  // Device under test with a short reset stretch.
  cgr_clock_gating_reset #(.TOUT_CYC(TOUT)) cgr_clock_gating_reset_i (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .poweron_low_in(poweron_low_in),
    .ext_reset_n_in(ext_reset_n_in), .wdt_expire_in(wdt_expire_in), .wdt_enable_in(wdt_enable_in),
    .brownout_low_in(brownout_low_in), .usb_bus_reset_in(usb_bus_reset_in),
    .usb_reset_mcu_en_in(usb_reset_mcu_en_in), .brownout_level_fuses_in(brownout_level_fuses_in),
    .debug_enable_fuse_in(debug_enable_fuse_in), .sleep_active_in(sleep_active_in),
    .comparator_enable_in(comparator_enable_in), .comparator_uses_ref_in(comparator_uses_ref_in),
    .wake_input_mask_in(wake_input_mask_in), .periph_sel_timer_a_in(sel_a), .periph_sel_timer_b_in(sel_b),
    .periph_sel_sync_serial_in(sel_s), .periph_sel_usb_in(sel_u), .periph_sel_serial_in(sel_p),
    .clk_en_out(clk_en_out), .periph_access_ok_out(periph_access_ok_out),
    .comparator_power_out(comparator_power_out), .vref_enable_out(vref_enable_out),
    .brownout_enable_out(brownout_enable_out), .wdt_run_out(wdt_run_out),
    .input_buffer_en_out(input_buffer_en_out), .main_clock_en_out(main_clock_en_out),
    .usb_keep_enabled_out(usb_keep_enabled_out), .port_reset_out(port_reset_out),
    .core_reset_out(core_reset_out));
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle; read data lands in rd at the acking edge.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_sel_in <= 4'hF;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (wb_ack_out !== 1'b1 && k < 20);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (k >= 20) chk(32'h0000_0000, 32'h0000_0001);
    @(posedge sys_clk_in);
  endtask : wb
  // Counts the edges during which the core reset is still stretched.
  task automatic settle();
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (core_reset_out === 1'b1 && n < 200);
  endtask : settle
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Clock, defaults, watchdog and test sequence.
  // ----------------------------------------------------------------
  // Free-running 40 MHz clock.
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    n_fail++;
    report_and_stop();
  end
  // Main sequence: every scenario judges its own results.
  initial begin
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, poweron_low_in, wdt_expire_in} = '0;
    {wdt_enable_in, brownout_low_in, usb_bus_reset_in, usb_reset_mcu_en_in, sleep_active_in} = '0;
    {comparator_enable_in, comparator_uses_ref_in, sel_a, sel_b, sel_s, sel_u, sel_p} = '0;
    {n_fail, samples_checked, debug_enable_fuse_in} = '0;
    {sys_rst_in, ext_reset_n_in, wb_sel_in, brownout_level_fuses_in, wake_input_mask_in} = {2'b11, 4'hF, 3'h7, 8'h0F};
    repeat (5) @(posedge sys_clk_in);
    test_reset();
    test_gating();
    test_power();
    test_sources();
    report_and_stop();
  end
  // Reset release: stretch length and gate B reset value.
  task automatic test_reset();
    chk(core_reset_out, 1);
    sys_rst_in <= 1'b0;
    settle();
    chk(n >= TOUT && n <= TOUT + 3, 1);
    wb(0, 4'h4, 0);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : test_reset
  // Gating bits, reserved bits, blocked access and an unmapped place.
  task automatic test_gating();
    wb(1, 4'h0, 32'h0000_00FF);
    wb(0, 4'h0, 0);
    chk(rd, 32'h0000_002C);
    chk(clk_en_out, 5'b00011);
    sel_a <= 1'b1;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk(periph_access_ok_out, 0);
    wb(1, 4'h4, 32'h0000_00FF);
    wb(0, 4'h4, 0);
    chk(rd, 32'h0000_0081);
    chk(clk_en_out, 5'b00000);
    wb(1, 4'h0, 0);
    wb(1, 4'h4, 0);
    chk(clk_en_out, 5'b11111);
    chk(periph_access_ok_out, 1);
    wb(1, 4'h2, 32'h0000_00FF);
    wb(0, 4'h2, 0);
    chk(rd, 32'h0000_0000);
    $display("test gating done");
  endtask : test_gating
  // Power-down sleep with detector, watchdog and debug fuse on.
  task automatic test_power();
    {brownout_level_fuses_in, comparator_enable_in, wdt_enable_in, debug_enable_fuse_in} <= 6'b110_111;
    wb(1, 4'hC, 32'h0000_0005);
    sleep_active_in <= 1'b1;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk(comparator_power_out, 0);
    chk({brownout_enable_out, vref_enable_out, wdt_run_out}, 3'b111);
    chk(input_buffer_en_out, 8'h0F);
    chk(main_clock_en_out, 1);
    {comparator_uses_ref_in, brownout_level_fuses_in} <= 4'b1_111;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk({comparator_power_out, vref_enable_out}, 2'b11);
    {sleep_active_in, comparator_enable_in} <= 2'b00;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk({vref_enable_out, input_buffer_en_out}, 9'h0FF);
    wb(1, 4'hC, 0);
    $display("test power done");
  endtask : test_power
  // Reset sources, stretch and cause flags.
  task automatic test_sources();
    wb(1, 4'h8, 0);
    wb(0, 4'h8, 0);
    chk(rd, 32'h0000_0000);
    {brownout_level_fuses_in, wdt_enable_in} <= 4'b110_0;
    wb(1, 4'h0, 32'h0000_0020);
    brownout_low_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk(core_reset_out, 1);
    brownout_low_in <= 1'b0;
    settle();
    chk(n >= TOUT && n <= TOUT + 3, 1);
    wb(0, 4'h0, 0);
    chk(rd, 32'h0000_0000);
    wdt_expire_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    wdt_expire_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chk(core_reset_out, 0);
    {wdt_enable_in, wdt_expire_in} <= 2'b11;
    repeat (3) @(posedge sys_clk_in);
    wdt_expire_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk(core_reset_out, 1);
    settle();
    ext_reset_n_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    chk(core_reset_out, 1);
    ext_reset_n_in <= 1'b1;
    settle();
    {usb_reset_mcu_en_in, usb_bus_reset_in} <= 2'b11;
    repeat (5) @(posedge sys_clk_in);
    chk({core_reset_out, usb_keep_enabled_out}, 2'b11);
    usb_bus_reset_in <= 1'b0;
    settle();
    wb(0, 4'h8, 0);
    chk(rd, 32'h0000_002E);
    poweron_low_in <= 1'b1;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    chk({port_reset_out, core_reset_out}, 2'b11);
    poweron_low_in <= 1'b0;
    settle();
    wb(0, 4'h8, 0);
    chk(rd, 32'h0000_0001);
    $display("test sources done");
  endtask : test_sources
endmodule : testbench
